/* hdl/cfp_addr_form.sv */
// working register address forming and bank check
`timescale 1ns/10ps
`default_nettype none
module cfp_addr_form
  import cfp_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // pointer and operand
  input  wire logic [7:0]  rp,
  input  wire logic [3:0]  operand,
  // outcome
  output logic      [7:0]  reg_addr,
  output logic             bank_valid
);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reg_addr <= 8'h00;
    end else begin
      reg_addr <= {rp[7:4], operand};
    end
  end

  // only banks 0, d, f valid
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bank_valid <= 1'b1;
    end else begin
      bank_valid <= cfp_bank_ok(rp[3:0]);
    end
  end

endmodule
`default_nettype wire

/* hdl/cfp_flag_calc.sv */
// flag and result evaluation for one alu operation
`timescale 1ns/10ps
`default_nettype none
module cfp_flag_calc
  import cfp_pkg::*;
(
  // operation
  input  wire cfp_op_t     op,
  input  wire logic [7:0]  a,
  input  wire logic [7:0]  b,
  input  wire logic [7:0]  cur_flags,
  // outcome
  output logic      [7:0]  result,
  output logic      [7:0]  new_flags
);

  logic       cin;
  logic       is_sub;
  logic [8:0] wide;
  logic [4:0] nib;
  int         sval;

  always_comb begin
    cin       = cur_flags[CFP_BIT_C];
    is_sub    = (op == CFP_OP_SUB) || (op == CFP_OP_SBC);
    new_flags = cur_flags;
    wide      = 9'h000;
    nib       = 5'h00;
    sval      = 0;
    result    = a;
    case (op)
      CFP_OP_ADD, CFP_OP_ADC, CFP_OP_SUB, CFP_OP_SBC: begin
        if (op == CFP_OP_ADD || op == CFP_OP_SUB) begin
          cin = 1'b0;
        end
        if (is_sub) begin
          wide = {1'b0, a} - {1'b0, b} - {8'h00, cin};
          nib  = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin};
          sval = $signed(a) - $signed(b) - int'(cin);
        end else begin
          wide = {1'b0, a} + {1'b0, b} + {8'h00, cin};
          nib  = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
          sval = $signed(a) + $signed(b) + int'(cin);
        end
        result = wide[7:0];
        new_flags[CFP_BIT_C] = wide[8];
        new_flags[CFP_BIT_V] = (sval > CFP_SIGNED_MAX) ||
                               (sval < CFP_SIGNED_MIN);
        new_flags[CFP_BIT_D] = is_sub;
        // carry or borrow at bit 3
        new_flags[CFP_BIT_H] = nib[CFP_NIB_MSB+1];
      end
      CFP_OP_AND, CFP_OP_OR, CFP_OP_XOR: begin
        if (op == CFP_OP_AND) begin
          result = a & b;
        end else if (op == CFP_OP_OR) begin
          result = a | b;
        end else begin
          result = a ^ b;
        end
        new_flags[CFP_BIT_V] = 1'b0;
      end
      CFP_OP_RL, CFP_OP_RLC, CFP_OP_RR, CFP_OP_RRC, CFP_OP_SRA: begin
        case (op)
          CFP_OP_RL:  result = {a[6:0], a[7]};
          CFP_OP_RLC: result = {a[6:0], cin};
          CFP_OP_RR:  result = {a[0], a[7:1]};
          CFP_OP_RRC: result = {cin, a[7:1]};
          default:    result = {a[7], a[7:1]};
        endcase
        new_flags[CFP_BIT_C] = (op == CFP_OP_RL || op == CFP_OP_RLC) ?
                               a[CFP_MSB] : a[0];
        new_flags[CFP_BIT_V] = result[CFP_MSB] ^ a[CFP_MSB];
      end
      default: begin
        result = a;
      end
    endcase
    new_flags[CFP_BIT_Z] = (result == 8'h00);
    new_flags[CFP_BIT_S] = result[CFP_MSB];
  end

endmodule
`default_nettype wire

/* hdl/cfp_pkg.sv */
// constants, types and helpers shared by the flags and pointers block
package cfp_pkg;

  // ****************************************
  // register map
  // ****************************************
  // printed offsets are indices; the apb byte address is four times each
  localparam int         CFP_ADDR_W    = 10;
  localparam logic [7:0] CFP_IDX_FLAGS = 8'hfc;
  localparam logic [7:0] CFP_IDX_RP    = 8'hfd;
  localparam logic [7:0] CFP_IDX_SP    = 8'hff;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [7:0] CFP_FLAGS_RST = 8'h00;
  localparam logic [7:0] CFP_RP_RST    = 8'h00;
  localparam logic [7:0] CFP_SP_RST    = 8'h00;

  // ****************************************
  // flag bit positions
  // ****************************************
  localparam int CFP_BIT_C   = 7;
  localparam int CFP_BIT_Z   = 6;
  localparam int CFP_BIT_S   = 5;
  localparam int CFP_BIT_V   = 4;
  localparam int CFP_BIT_D   = 3;
  localparam int CFP_BIT_H   = 2;
  localparam int CFP_BIT_UHI = 1;
  localparam int CFP_BIT_ULO = 0;

  // ****************************************
  // arithmetic limits and bank codes
  // ****************************************
  localparam int         CFP_SIGNED_MAX = 127;
  localparam int         CFP_SIGNED_MIN = -128;
  localparam int         CFP_MSB        = 7;
  localparam int         CFP_NIB_MSB    = 3;
  localparam logic [3:0] CFP_BANK_STD   = 4'h0;
  localparam logic [3:0] CFP_BANK_D     = 4'hd;
  localparam logic [3:0] CFP_BANK_F     = 4'hf;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [3:0] {
    CFP_OP_ADD, CFP_OP_ADC, CFP_OP_SUB, CFP_OP_SBC,
    CFP_OP_AND, CFP_OP_OR,  CFP_OP_XOR,
    CFP_OP_RL,  CFP_OP_RLC, CFP_OP_RR,  CFP_OP_RRC, CFP_OP_SRA
  } cfp_op_t;

  typedef enum logic [1:0] {
    CFP_COND_C, CFP_COND_Z, CFP_COND_S, CFP_COND_V
  } cfp_cond_t;

  typedef enum logic {CFP_APB_IDLE, CFP_APB_ANSWER} cfp_apb_state_t;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [CFP_ADDR_W-1:0] cfp_byte_addr(
    input logic [7:0] idx);
    return {idx, 2'b00};
  endfunction

  function automatic logic cfp_bank_ok(input logic [3:0] bank);
    return (bank == CFP_BANK_STD) || (bank == CFP_BANK_D) ||
           (bank == CFP_BANK_F);
  endfunction

endpackage

/* hdl/cfp_regs.sv */
// flags, register pointer and stack pointer with apb access
//
// Local design decision: register access over APB.
`timescale 1ns/10ps
`default_nettype none
module cfp_regs
  import cfp_pkg::*;
(
  // clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // apb slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [CFP_ADDR_W-1:0] paddr,
  input  wire logic [31:0]           pwdata,
  output logic                       pready,
  output logic      [31:0]           prdata,
  output logic                       pslverr,
  // alu operation
  input  wire logic                  alu_valid,
  input  wire cfp_op_t               alu_op,
  input  wire logic [7:0]            alu_a,
  input  wire logic [7:0]            alu_b,
  output logic      [7:0]            alu_result,
  // explicit instruction writes
  input  wire logic                  flag_wr_en,
  input  wire logic [7:0]            flag_wr_data,
  input  wire logic                  rp_wr_en,
  input  wire logic [7:0]            rp_wr_data,
  input  wire logic                  sp_wr_en,
  input  wire logic [7:0]            sp_wr_data,
  // stack
  input  wire logic                  sp_push,
  input  wire logic                  sp_pop,
  // jump condition
  input  wire cfp_cond_t             cond_sel,
  output logic                       cond_true,
  // working register addressing
  input  wire logic [3:0]            wr_operand,
  output logic      [7:0]            reg_addr,
  output logic                       bank_valid,
  // register state
  output logic      [7:0]            flags,
  output logic      [7:0]            rp,
  output logic      [7:0]            sp
);

  // ****************************************
  // apb decode
  // ****************************************
  cfp_apb_state_t state;
  logic           access;
  logic           wr_take;
  logic           hit_flags;
  logic           hit_rp;
  logic           hit_sp;
  logic [7:0]     next_rdata;

  assign access    = psel && penable;
  assign wr_take   = access && pready && pwrite;
  assign hit_flags = (paddr == cfp_byte_addr(CFP_IDX_FLAGS));
  assign hit_rp    = (paddr == cfp_byte_addr(CFP_IDX_RP));
  assign hit_sp    = (paddr == cfp_byte_addr(CFP_IDX_SP));

  always_comb begin
    next_rdata = 8'h00;
    if (hit_flags) begin
      next_rdata = flags;
    end else if (hit_rp) begin
      next_rdata = rp;
    end else if (hit_sp) begin
      next_rdata = sp;
    end
  end

  // one wait state so the answer leaves a flip-flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= CFP_APB_IDLE;
    end else begin
      case (state)
        CFP_APB_IDLE: begin
          if (access) begin
            state <= CFP_APB_ANSWER;
          end
        end
        CFP_APB_ANSWER: begin
          state <= CFP_APB_IDLE;
        end
        default: begin
          state <= CFP_APB_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= (state == CFP_APB_IDLE) && access;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
      if ((state == CFP_APB_IDLE) && access) begin
        prdata  <= pwrite ? 32'h0000_0000 : {24'h00_0000, next_rdata};
        pslverr <= !(hit_flags || hit_rp || hit_sp);
      end
    end
  end

  // ****************************************
  // flag register
  // ****************************************
  logic [7:0] calc_result;
  logic [7:0] calc_flags;
  logic       explicit_flag_wr;

  cfp_flag_calc u_calc (
    .op        (alu_op),
    .a         (alu_a),
    .b         (alu_b),
    .cur_flags (flags),
    .result    (calc_result),
    .new_flags (calc_flags)
  );

  assign explicit_flag_wr = (wr_take && hit_flags) || flag_wr_en;

  // explicit write wins over alu update
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags <= CFP_FLAGS_RST;
    end else if (wr_take && hit_flags) begin
      flags <= pwdata[7:0];
    end else if (flag_wr_en) begin
      flags <= flag_wr_data;
    end else if (alu_valid) begin
      flags <= calc_flags;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alu_result <= 8'h00;
    end else if (alu_valid) begin
      alu_result <= calc_result;
    end
  end

  // half carry, decimal and user bits not selectable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cond_true <= 1'b0;
    end else begin
      case (cond_sel)
        CFP_COND_C: cond_true <= flags[CFP_BIT_C];
        CFP_COND_Z: cond_true <= flags[CFP_BIT_Z];
        CFP_COND_S: cond_true <= flags[CFP_BIT_S];
        CFP_COND_V: cond_true <= flags[CFP_BIT_V];
        default:    cond_true <= 1'b0;
      endcase
    end
  end

  // ****************************************
  // register pointer
  // ****************************************
  // upper nibble is the working group
  // lower nibble is the expanded bank
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rp <= CFP_RP_RST;
    end else if (wr_take && hit_rp) begin
      rp <= pwdata[7:0];
    end else if (rp_wr_en) begin
      rp <= rp_wr_data;
    end
  end

  // invalid banks are stored; software sees bank_valid low
  cfp_addr_form u_addr (
    .pclk       (pclk),
    .presetn    (presetn),
    .rp         (rp),
    .operand    (wr_operand),
    .reg_addr   (reg_addr),
    .bank_valid (bank_valid)
  );

  // ****************************************
  // stack pointer
  // ****************************************
  // single pointer, push predecrements
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sp <= CFP_SP_RST;
    end else if (wr_take && hit_sp) begin
      sp <= pwdata[7:0];
    end else if (sp_wr_en) begin
      sp <= sp_wr_data;
    end else if (sp_push && !sp_pop) begin
      sp <= sp - 8'h01;
    end else if (sp_pop && !sp_push) begin
      sp <= sp + 8'h01;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic alu_only;
  assign alu_only = alu_valid && !explicit_flag_wr;

  carry_add_a: assert property (
    alu_only && alu_op == CFP_OP_ADD |=>
      flags[CFP_BIT_C] == ((9'({$past(alu_a)}) + 9'({$past(alu_b)})) > 9'h0ff))
    else $error("carry flag wrong after add");

  zero_flag_a: assert property (
    alu_only |=> flags[CFP_BIT_Z] == (alu_result == 8'h00))
    else $error("zero flag disagrees with result");

  sign_flag_a: assert property (
    alu_only |=> flags[CFP_BIT_S] == alu_result[CFP_MSB])
    else $error("sign flag disagrees with result msb");

  logic_ovf_a: assert property (
    alu_only && alu_op inside {CFP_OP_AND, CFP_OP_OR, CFP_OP_XOR} |=>
      !flags[CFP_BIT_V])
    else $error("overflow set after logic operation");

  dec_adjust_a: assert property (
    alu_only && alu_op inside {CFP_OP_ADD, CFP_OP_SUB} |=>
      flags[CFP_BIT_D] == $past(alu_op == CFP_OP_SUB))
    else $error("decimal adjust flag wrong");

  half_carry_a: assert property (
    alu_only && alu_op == CFP_OP_ADD |=>
      flags[CFP_BIT_H] == ((5'($past(alu_a[3:0])) +
                            5'($past(alu_b[3:0]))) > 5'h0f))
    else $error("half carry flag wrong after add");

  jump_cond_a: assert property (
    cond_sel == CFP_COND_Z |=> cond_true == $past(flags[CFP_BIT_Z]))
    else $error("jump condition not from zero flag");

  user_bits_a: assert property (
    !explicit_flag_wr |=> $stable(flags[1:0]))
    else $error("user flags changed without explicit write");

  work_addr_a: assert property (
    ##1 reg_addr == {$past(rp[7:4]), $past(wr_operand)})
    else $error("working register address wrong");

  bank_check_a: assert property (
    rp[3:0] == 4'h5 |=> !bank_valid)
    else $error("bank 5 reported valid");

  stack_push_a: assert property (
    sp_push && !sp_pop && !sp_wr_en && !(wr_take && hit_sp) |=>
      sp == $past(sp) - 8'h01)
    else $error("stack pointer not decremented on push");

  explicit_wins_a: assert property (
    flag_wr_en && alu_valid && !(wr_take && hit_flags) |=>
      flags == $past(flag_wr_data))
    else $error("explicit flag write lost to alu");

  apb_answer_a: assert property (
    access && state == CFP_APB_IDLE |=> pready ##1 !pready)
    else $error("apb answer not one cycle after access");

endmodule
`default_nettype wire

/* tb/cfp_core_model.sv */
// alu and instruction sequencer model on the core side of the block
`timescale 1ns/10ps
`default_nettype none
module cfp_core_model
  import cfp_pkg::*;
(
  // clock
  input  wire logic       pclk,
  // alu request
  output logic            alu_valid,
  output var cfp_op_t     alu_op,
  output logic      [7:0] alu_a,
  output logic      [7:0] alu_b,
  // explicit writes and stack
  output logic            flag_wr_en,
  output logic      [7:0] flag_wr_data,
  output logic            rp_wr_en,
  output logic      [7:0] rp_wr_data,
  output logic            sp_wr_en,
  output logic      [7:0] sp_wr_data,
  output logic            sp_push,
  output logic            sp_pop,
  // selection
  output var cfp_cond_t   cond_sel,
  output logic      [3:0] wr_operand
);
  initial begin
    {alu_valid, flag_wr_en, rp_wr_en, sp_wr_en, sp_push, sp_pop} = 6'h00;
    {alu_a, alu_b, flag_wr_data, rp_wr_data, sp_wr_data} = 40'h00_0000_0000;
    alu_op = CFP_OP_ADD;
    cond_sel = CFP_COND_C;
    wr_operand = 4'h0;
  end

  // one cycle of strobes: en = {alu, flag, rp, sp, push, pop}
  task automatic pulse(input logic [5:0] en, input logic [7:0] d,
                       input cfp_op_t o, input logic [7:0] a, b);
    @(posedge pclk);
    {alu_valid, flag_wr_en, rp_wr_en, sp_wr_en, sp_push, sp_pop} <= en;
    {flag_wr_data, rp_wr_data, sp_wr_data} <= {d, d, d};
    alu_op <= o;
    alu_a <= a;
    alu_b <= b;
    @(posedge pclk);
    {alu_valid, flag_wr_en, rp_wr_en, sp_wr_en, sp_push, sp_pop} <= 6'h00;
    // released data lines toggle rather than keep the old value
    {flag_wr_data, rp_wr_data, sp_wr_data} <= ~{d, d, d};
    {alu_a, alu_b} <= ~{a, b};
  endtask

  task automatic sel(input cfp_cond_t c, input logic [3:0] w);
    @(posedge pclk);
    cond_sel <= c;
    wr_operand <= w;
  endtask
endmodule
`default_nettype wire

/* tb/tb.sv */
// self-checking bench for the flags and pointers block
`timescale 1ns/10ps
`default_nettype none
module tb
  import cfp_pkg::*;
;
  typedef struct packed {
    cfp_op_t op; logic [7:0] a, b, init, res, flg;
  } cfp_vec_t;
  localparam cfp_vec_t TBL [13] = '{
    '{CFP_OP_ADD, 8'h7f, 8'h01, 8'h03, 8'h80, 8'h37},
    '{CFP_OP_ADD, 8'hff, 8'h01, 8'h03, 8'h00, 8'hc7},
    '{CFP_OP_ADC, 8'h00, 8'h00, 8'h83, 8'h01, 8'h03},
    '{CFP_OP_SUB, 8'h00, 8'h01, 8'h03, 8'hff, 8'haf},
    '{CFP_OP_SBC, 8'h05, 8'h02, 8'h83, 8'h02, 8'h0b},
    '{CFP_OP_AND, 8'hf0, 8'h0f, 8'haf, 8'h00, 8'hcf},
    '{CFP_OP_OR,  8'h00, 8'h00, 8'h03, 8'h00, 8'h43},
    '{CFP_OP_XOR, 8'h80, 8'h00, 8'h03, 8'h80, 8'h23},
    '{CFP_OP_RL,  8'h80, 8'h00, 8'h0f, 8'h01, 8'h9f},
    '{CFP_OP_RLC, 8'h80, 8'h00, 8'h03, 8'h00, 8'hd3},
    '{CFP_OP_RR,  8'h01, 8'h00, 8'h03, 8'h80, 8'hb3},
    '{CFP_OP_RRC, 8'h01, 8'h00, 8'h83, 8'h80, 8'hb3},
    '{CFP_OP_SRA, 8'h81, 8'h00, 8'h03, 8'hc0, 8'ha3}};

  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [9:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        alu_valid, flag_wr_en, rp_wr_en, sp_wr_en, sp_push, sp_pop;
  cfp_op_t     alu_op;
  cfp_cond_t   cond_sel;
  logic [7:0]  alu_a, alu_b, alu_result, flag_wr_data, rp_wr_data;
  logic [7:0]  sp_wr_data, reg_addr, flags, rp, sp;
  logic [3:0]  wr_operand;
  logic        cond_true, bank_valid;
  int          err_count = 0;
  int          n_checks = 0;

  cfp_regs u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .alu_valid(alu_valid), .alu_op(alu_op), .alu_a(alu_a), .alu_b(alu_b),
    .alu_result(alu_result), .flag_wr_en(flag_wr_en),
    .flag_wr_data(flag_wr_data), .rp_wr_en(rp_wr_en),
    .rp_wr_data(rp_wr_data), .sp_wr_en(sp_wr_en), .sp_wr_data(sp_wr_data),
    .sp_push(sp_push), .sp_pop(sp_pop), .cond_sel(cond_sel),
    .cond_true(cond_true), .wr_operand(wr_operand), .reg_addr(reg_addr),
    .bank_valid(bank_valid), .flags(flags), .rp(rp), .sp(sp));
  cfp_core_model u_seq (.pclk(pclk), .alu_valid(alu_valid),
    .alu_op(alu_op), .alu_a(alu_a), .alu_b(alu_b),
    .flag_wr_en(flag_wr_en), .flag_wr_data(flag_wr_data),
    .rp_wr_en(rp_wr_en), .rp_wr_data(rp_wr_data), .sp_wr_en(sp_wr_en),
    .sp_wr_data(sp_wr_data), .sp_push(sp_push), .sp_pop(sp_pop),
    .cond_sel(cond_sel), .wr_operand(wr_operand));

  always #4 pclk = ~pclk;

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ****************************************
  // apb master
  // ****************************************
  task automatic apb(input logic w, input logic [7:0] ix,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic er);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {ix, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~wd;
    if (n >= 50) err_count++;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_regs();
    logic [31:0] d;
    logic        e;
    logic [7:0]  a;
    apb(1'b0, CFP_IDX_RP, 32'h0, d, e);
    chk("rp reset read", d, 32'h0000_0000);
    for (int i = 0; i < 3; i++) begin
      a = (i == 0) ? CFP_IDX_FLAGS : (i == 1) ? CFP_IDX_RP : CFP_IDX_SP;
      apb(1'b1, a, 32'hffff_ff5a + 32'(i), d, e);
      apb(1'b0, a, 32'h0000_0000, d, e);
      chk("rw readback", d, 32'h0000_005a + 32'(i));
      chk("rw error", {31'h0, e}, 32'h0);
    end
    // unmapped reads give zero with an error, writes change nothing
    apb(1'b1, 8'hfe, 32'h0000_00ff, d, e);
    chk("unmapped wr err", {31'h0, e}, 32'h1);
    apb(1'b0, 8'h00, 32'h0, d, e);
    chk("unmapped rd err", {31'h0, e}, 32'h1);
    chk("unmapped rd data", d, 32'h0);
    chk("sp untouched", {24'h0, sp}, 32'h0000_005c);
    chk("rp untouched", {24'h0, rp}, 32'h0000_005b);
  endtask

  task automatic t_alu();
    foreach (TBL[i]) begin
      u_seq.pulse(6'h10, TBL[i].init, CFP_OP_ADD, 8'h00, 8'h00);
      u_seq.pulse(6'h20, 8'h00, TBL[i].op, TBL[i].a, TBL[i].b);
      #1;
      chk("alu result", {24'h0, alu_result}, {24'h0, TBL[i].res});
      chk("alu flags", {24'h0, flags}, {24'h0, TBL[i].flg});
    end
    u_seq.pulse(6'h30, 8'h5a, CFP_OP_ADD, 8'hff, 8'h01);
    #1;
    chk("write beats alu", {24'h0, flags}, 32'h0000_005a);
  endtask

  task automatic t_cond();
    logic [7:0] v;
    for (int k = 0; k < 3; k++) begin
      v = (k == 0) ? 8'ha0 : (k == 1) ? 8'h5f : 8'h0f;
      u_seq.pulse(6'h10, v, CFP_OP_ADD, 8'h00, 8'h00);
      for (int c = 0; c < 4; c++) begin
        u_seq.sel(cfp_cond_t'(c), 4'h0);
        @(posedge pclk);
        #1;
        chk("jump condition", {31'h0, cond_true}, {31'h0, v[7-c]});
      end
    end
  endtask

  task automatic t_ptr();
    logic [3:0] b;
    for (int i = 0; i < 16; i++) begin
      b = 4'(i);
      u_seq.pulse(6'h08, {~b, b}, CFP_OP_ADD, 8'h00, 8'h00);
      u_seq.sel(CFP_COND_C, ~b);
      @(posedge pclk);
      #1;
      chk("reg addr", {24'h0, reg_addr}, {24'h0, ~b, ~b});
      chk("bank ok", {31'h0, bank_valid},
          {31'h0, b == 4'h0 || b == 4'hd || b == 4'hf});
    end
  endtask

  task automatic t_stack();
    logic [31:0] d;
    logic        e;
    u_seq.pulse(6'h04, 8'h00, CFP_OP_ADD, 8'h00, 8'h00);
    u_seq.pulse(6'h02, 8'h00, CFP_OP_ADD, 8'h00, 8'h00);
    #1;
    chk("push wraps", {24'h0, sp}, 32'h0000_00ff);
    u_seq.pulse(6'h01, 8'h00, CFP_OP_ADD, 8'h00, 8'h00);
    #1;
    chk("pop wraps", {24'h0, sp}, 32'h0000_0000);
    u_seq.pulse(6'h03, 8'h00, CFP_OP_ADD, 8'h00, 8'h00);
    #1;
    chk("push and pop", {24'h0, sp}, 32'h0000_0000);
    u_seq.pulse(6'h04, 8'h40, CFP_OP_ADD, 8'h00, 8'h00);
    u_seq.pulse(6'h02, 8'h00, CFP_OP_ADD, 8'h00, 8'h00);
    apb(1'b0, CFP_IDX_SP, 32'h0, d, e);
    chk("sp read", d, 32'h0000_003f);
  endtask

  initial begin
    #50000;
    err_count++;
    wrap_up();
  end

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = 45'h0;
    repeat (20) @(posedge pclk);
    #1;
    chk("reset state", {flags, rp, sp}, 32'h0000_0000);
    chk("reset bank", {31'h0, bank_valid}, 32'h1);
    @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_alu();
    t_cond();
    t_ptr();
    t_stack();
    wrap_up();
  end
endmodule
`default_nettype wire
